// ===== core/ivf_pkg.sv
// Package of constants for the input-voltage fault response block.
// Assumes a 40 MHz system clock and the command-code register port of the top module.
package ivf_pkg;

	// ------------------------------------------------------------------
	// Register command codes
	// ------------------------------------------------------------------
	localparam logic [7:0]  ADDR_OV_WARN     = 8'h57;
	localparam logic [7:0]  ADDR_UV_WARN     = 8'h58;
	localparam logic [7:0]  ADDR_UV_FAULT    = 8'h59;
	localparam logic [7:0]  ADDR_UV_ACTION   = 8'h5A;
	localparam logic [7:0]  ADDR_STATUS      = 8'h7C;
	localparam logic [7:0]  ADDR_TIME_UNIT   = 8'hD2;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          RESP_HI          = 7;
	localparam int          RESP_LO          = 6;
	localparam int          RETRY_HI         = 5;
	localparam int          RETRY_LO         = 3;
	localparam int          DELAY_HI         = 2;
	localparam int          DELAY_LO         = 0;
	localparam int          ST_UV_FAULT_BIT  = 0;
	localparam int          ST_UV_WARN_BIT   = 1;
	localparam int          ST_OV_WARN_BIT   = 2;

	// ------------------------------------------------------------------
	// Field encodings
	// ------------------------------------------------------------------
	localparam logic [1:0]  RESP_IGNORE      = 2'h0;
	localparam logic [1:0]  RESP_RIDE        = 2'h1;
	localparam logic [1:0]  RESP_DISABLE     = 2'h2;
	localparam logic [1:0]  RESP_LATCH       = 2'h3;
	localparam logic [2:0]  RETRY_NONE       = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER    = 3'h7;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_THRESHOLD    = 16'h0000;
	localparam logic [7:0]  RST_ACTION       = 8'h00;
	localparam logic [15:0] RST_TIME_UNIT    = 16'h0001;

	// ------------------------------------------------------------------
	// Timing: one time unit step is one microsecond
	// ------------------------------------------------------------------
	localparam int          CLK_HZ           = 40000000;
	localparam int          STEP_NS          = 1000;
	localparam int          STEP_CYCLES      = STEP_NS / (1000000000 / CLK_HZ);
	localparam logic [5:0]  STEP_LAST        = 6'(STEP_CYCLES - 1);

	// ------------------------------------------------------------------
	// Fault handling states
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_RIDE  = 4'b0010,
		ST_WAIT  = 4'b0100,
		ST_LATCH = 4'b1000
	} ivf_state_e;

endpackage

// ===== core/ivf_top.sv
// Input-voltage supervision: thresholds, warnings and under-voltage fault response.
// Assumes one 40 MHz clock, synchronous inputs and a host that writes by command code.
// Behaviour
// - Read/write 16-bit input over-voltage warning threshold, linear format volts.
// - Read/write 16-bit input under-voltage warning threshold, linear format volts.
// - Read/write 16-bit input under-voltage fault threshold, linear format volts.
// - Response code zero ignores the under-voltage fault and keeps running.
// - Code one rides through the delay, then follows retry field if fault persists.
// - Code two disables output at once, then follows the retry field.
// - Code three stays off until status clear, clear-faults, reset or off-on.
// - Retry field zero never restarts; output stays off until cleared.
// - Retry field one to six tries that many restarts, then latches off.
// - Retry field seven retries forever until commanded off; another fault is not checked while waiting.
// - Restart attempts are spaced start to start by two to the delay field time units.
// - Delay field n means two to the n time units, 1 to 128.
// - The time unit length comes from the separate time-unit register.
`timescale 1ns/10ps
module ivf_top (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	// Register command port
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] wr_data_i,
	output logic      [15:0] rd_data_o,
	output logic             rd_valid_o,
	// Converter control and measurement
	input  wire logic        clear_faults_i,
	input  wire logic        on_cmd_i,
	input  wire logic        other_fault_i,
	input  wire logic [15:0] vin_meas_i,
	// Status outputs
	output logic             out_enable_o,
	output logic             uv_fault_o,
	output logic             uv_warn_o,
	output logic             ov_warn_o
);

	// ------------------------------------------------------------------
	// Linear format to fixed point
	// ------------------------------------------------------------------
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
		logic [5:0] sh;
		sh = 6'($signed({w[15], w[15:11]}) + 6'sd16);
		return $signed({{37{w[10]}}, w[10:0]}) <<< sh;
	endfunction

	logic signed [47:0] vin_fix;
	logic               uv_fault_now;
	logic               uv_warn_now;
	logic               ov_warn_now;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [15:0] ov_warn_thr_reg,   ov_warn_thr_next;
	logic [15:0] uv_warn_thr_reg,   uv_warn_thr_next;
	logic [15:0] uv_fault_thr_reg,  uv_fault_thr_next;
	logic [7:0]  uv_action_reg,     uv_action_next;
	logic [15:0] time_unit_reg,     time_unit_next;
	logic [2:0]  status_reg,        status_next;
	logic [15:0] rd_data_reg,       rd_data_next;
	logic        rd_valid_reg,      rd_valid_next;
	logic        status_clr_fault;

	always_comb begin
		vin_fix      = lin_to_fix(vin_meas_i);
		uv_fault_now = vin_fix < lin_to_fix(uv_fault_thr_reg);
		uv_warn_now  = vin_fix < lin_to_fix(uv_warn_thr_reg);
		ov_warn_now  = vin_fix > lin_to_fix(ov_warn_thr_reg);
	end

	always_comb begin
		ov_warn_thr_next  = ov_warn_thr_reg;
		uv_warn_thr_next  = uv_warn_thr_reg;
		uv_fault_thr_next = uv_fault_thr_reg;
		uv_action_next    = uv_action_reg;
		time_unit_next    = time_unit_reg;
		status_clr_fault  = 1'b0;
		status_next       = status_reg;
		if (wr_en_i) begin
			case (cmd_code_i)
				ivf_pkg::ADDR_OV_WARN:   ov_warn_thr_next  = wr_data_i;
				ivf_pkg::ADDR_UV_WARN:   uv_warn_thr_next  = wr_data_i;
				ivf_pkg::ADDR_UV_FAULT:  uv_fault_thr_next = wr_data_i;
				ivf_pkg::ADDR_UV_ACTION: uv_action_next    = wr_data_i[7:0];
				ivf_pkg::ADDR_TIME_UNIT: time_unit_next    = wr_data_i;
				ivf_pkg::ADDR_STATUS: begin
					status_next      = status_reg & ~wr_data_i[2:0];
					status_clr_fault = wr_data_i[ivf_pkg::ST_UV_FAULT_BIT];
				end
				default: ;
			endcase
		end
		if (clear_faults_i) begin
			status_next = 3'h0;
		end
		// Events arriving with a clear still set their flag.
		if (uv_fault_now) status_next[ivf_pkg::ST_UV_FAULT_BIT] = 1'b1;
		if (uv_warn_now)  status_next[ivf_pkg::ST_UV_WARN_BIT]  = 1'b1;
		if (ov_warn_now)  status_next[ivf_pkg::ST_OV_WARN_BIT]  = 1'b1;
		rd_valid_next = rd_en_i;
		rd_data_next  = 16'h0000;
		if (rd_en_i) begin
			case (cmd_code_i)
				ivf_pkg::ADDR_OV_WARN:   rd_data_next = ov_warn_thr_reg;
				ivf_pkg::ADDR_UV_WARN:   rd_data_next = uv_warn_thr_reg;
				ivf_pkg::ADDR_UV_FAULT:  rd_data_next = uv_fault_thr_reg;
				ivf_pkg::ADDR_UV_ACTION: rd_data_next = {8'h00, uv_action_reg};
				ivf_pkg::ADDR_TIME_UNIT: rd_data_next = time_unit_reg;
				ivf_pkg::ADDR_STATUS:    rd_data_next = {13'h0000, status_reg};
				default:                 rd_data_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ov_warn_thr_reg  <= ivf_pkg::RST_THRESHOLD;
			uv_warn_thr_reg  <= ivf_pkg::RST_THRESHOLD;
			uv_fault_thr_reg <= ivf_pkg::RST_THRESHOLD;
			uv_action_reg    <= ivf_pkg::RST_ACTION;
			time_unit_reg    <= ivf_pkg::RST_TIME_UNIT;
			status_reg       <= 3'h0;
			rd_data_reg      <= 16'h0000;
			rd_valid_reg     <= 1'b0;
		end else begin
			ov_warn_thr_reg  <= ov_warn_thr_next;
			uv_warn_thr_reg  <= uv_warn_thr_next;
			uv_fault_thr_reg <= uv_fault_thr_next;
			uv_action_reg    <= uv_action_next;
			time_unit_reg    <= time_unit_next;
			status_reg       <= status_next;
			rd_data_reg      <= rd_data_next;
			rd_valid_reg     <= rd_valid_next;
		end
	end

	// ------------------------------------------------------------------
	// Fault response sequencer
	// ------------------------------------------------------------------
	logic [1:0]  resp;
	logic [2:0]  retry;
	logic [22:0] span;
	logic        tick;
	logic        expired;
	logic        release_req;
	logic [31:0] dwell_reg,     dwell_next;
	logic [5:0]  step_reg,      step_next;
	logic [22:0] ticks_reg,     ticks_next;
	logic [2:0]  tries_reg,     tries_next;
	ivf_pkg::ivf_state_e state_reg, state_next;

	always_comb begin
		resp        = uv_action_reg[ivf_pkg::RESP_HI:ivf_pkg::RESP_LO];
		retry       = uv_action_reg[ivf_pkg::RETRY_HI:ivf_pkg::RETRY_LO];
		span = 23'(time_unit_reg) << uv_action_reg[ivf_pkg::DELAY_HI:ivf_pkg::DELAY_LO];
		tick        = (step_reg == ivf_pkg::STEP_LAST);
		expired     = tick && (ticks_reg + 23'h000001 >= span);
		release_req = clear_faults_i || status_clr_fault;
		step_next   = tick ? 6'h00 : step_reg + 6'h01;
		ticks_next  = tick ? ticks_reg + 23'h000001 : ticks_reg;
		tries_next  = tries_reg;
		state_next  = state_reg;
		case (state_reg)
			ivf_pkg::ST_RUN: begin
				step_next  = 6'h00;
				ticks_next = 23'h000000;
				tries_next = 3'h0;
				if (on_cmd_i && other_fault_i) begin
					state_next = ivf_pkg::ST_LATCH;
				end else if (on_cmd_i && uv_fault_now) begin
					case (resp)
						ivf_pkg::RESP_IGNORE:  state_next = ivf_pkg::ST_RUN;
						ivf_pkg::RESP_RIDE:    state_next = ivf_pkg::ST_RIDE;
						ivf_pkg::RESP_DISABLE: state_next = (retry == ivf_pkg::RETRY_NONE) ?
							ivf_pkg::ST_LATCH : ivf_pkg::ST_WAIT;
						default:               state_next = ivf_pkg::ST_LATCH;
					endcase
				end
			end
			ivf_pkg::ST_RIDE: begin
				if (!uv_fault_now) begin
					state_next = ivf_pkg::ST_RUN;
				end else if (expired) begin
					ticks_next = 23'h000000;
					state_next = (retry == ivf_pkg::RETRY_NONE) ?
						ivf_pkg::ST_LATCH : ivf_pkg::ST_WAIT;
				end
			end
			ivf_pkg::ST_WAIT: begin
				if (expired) begin
					ticks_next = 23'h000000;
					if (retry != ivf_pkg::RETRY_FOREVER && tries_reg >= retry) begin
						state_next = ivf_pkg::ST_LATCH;
					end else if (!uv_fault_now) begin
						state_next = ivf_pkg::ST_RUN;
					end else if (retry != ivf_pkg::RETRY_FOREVER) begin
						tries_next = tries_reg + 3'h1;
					end
				end
			end
			ivf_pkg::ST_LATCH: begin
				ticks_next = 23'h000000;
				if (release_req) begin
					state_next = ivf_pkg::ST_RUN;
				end
			end
			default: state_next = ivf_pkg::ST_RUN;
		endcase
		// Commanding off stops retries and ends any latch.
		if (!on_cmd_i) begin
			state_next = ivf_pkg::ST_RUN;
		end
		dwell_next = (state_next == state_reg) ? dwell_reg + 32'h00000001 : 32'h00000000;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_reg    <= ivf_pkg::ST_RUN;
			step_reg     <= 6'h00;
			ticks_reg    <= 23'h000000;
			tries_reg    <= 3'h0;
			dwell_reg    <= 32'h00000000;
		end else begin
			state_reg    <= state_next;
			step_reg     <= step_next;
			ticks_reg    <= ticks_next;
			tries_reg    <= tries_next;
			dwell_reg    <= dwell_next;
		end
	end

	assign rd_data_o    = rd_data_reg;
	assign rd_valid_o   = rd_valid_reg;
	assign out_enable_o = on_cmd_i && (state_reg == ivf_pkg::ST_RUN || state_reg == ivf_pkg::ST_RIDE);
	assign uv_fault_o   = status_reg[ivf_pkg::ST_UV_FAULT_BIT];
	assign uv_warn_o    = status_reg[ivf_pkg::ST_UV_WARN_BIT];
	assign ov_warn_o    = status_reg[ivf_pkg::ST_OV_WARN_BIT];

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	chk_ov_readback: assert property (wr_en_i && cmd_code_i == ivf_pkg::ADDR_OV_WARN ##1 rd_en_i
		&& cmd_code_i == ivf_pkg::ADDR_OV_WARN |=> rd_data_o == $past(wr_data_i, 2))
		else $error("over-voltage threshold readback mismatch");
	chk_uvw_readback: assert property (wr_en_i && cmd_code_i == ivf_pkg::ADDR_UV_WARN ##1 rd_en_i
		&& cmd_code_i == ivf_pkg::ADDR_UV_WARN |=> rd_data_o == $past(wr_data_i, 2))
		else $error("under-voltage warning readback mismatch");
	chk_uvf_readback: assert property (wr_en_i && cmd_code_i == ivf_pkg::ADDR_UV_FAULT ##1 rd_en_i
		&& cmd_code_i == ivf_pkg::ADDR_UV_FAULT |=> rd_data_o == $past(wr_data_i, 2))
		else $error("under-voltage fault readback mismatch");
	chk_ignore_runs: assert property (state_reg == ivf_pkg::ST_RUN && on_cmd_i && !other_fault_i
		&& resp == ivf_pkg::RESP_IGNORE |=> out_enable_o || !on_cmd_i)
		else $error("ignore response disabled the output");
	chk_disable_now: assert property (state_reg == ivf_pkg::ST_RUN && on_cmd_i && uv_fault_now
		&& resp == ivf_pkg::RESP_DISABLE |=> !out_enable_o)
		else $error("disable response left output on");
	chk_latch_holds: assert property (state_reg == ivf_pkg::ST_LATCH && on_cmd_i && !release_req
		|=> state_reg == ivf_pkg::ST_LATCH)
		else $error("latched shutdown released without a clear");
	chk_no_retry: assert property (state_reg == ivf_pkg::ST_WAIT |-> retry != ivf_pkg::RETRY_NONE
		|| $past(retry) != ivf_pkg::RETRY_NONE)
		else $error("retry wait entered with retries off");
	chk_try_limit: assert property (state_reg == ivf_pkg::ST_WAIT && retry != ivf_pkg::RETRY_FOREVER
		&& $stable(retry) |-> tries_reg <= retry)
		else $error("restart count exceeded the limit");
	chk_off_stops: assert property (!on_cmd_i |=> state_reg == ivf_pkg::ST_RUN && !out_enable_o
		|| on_cmd_i)
		else $error("off command did not stop fault handling");
	chk_span_wait: assert property (state_reg == ivf_pkg::ST_RIDE && on_cmd_i
		&& (state_next == ivf_pkg::ST_WAIT || state_next == ivf_pkg::ST_LATCH)
		|-> dwell_reg + 32'h00000001 == (32'(time_unit_reg) * 32'(ivf_pkg::STEP_CYCLES))
		<< uv_action_reg[ivf_pkg::DELAY_HI:ivf_pkg::DELAY_LO])
		else $error("ride-through ended at the wrong time");
	chk_uv_flag: assert property (uv_fault_now |=> uv_fault_o)
		else $error("under-voltage fault flag not set");

	cov_ride_recover: cover property (state_reg == ivf_pkg::ST_RIDE ##1 state_reg == ivf_pkg::ST_RUN);
	cov_retry_ok:     cover property (state_reg == ivf_pkg::ST_WAIT ##1 state_reg == ivf_pkg::ST_RUN);
	cov_latched:      cover property (state_reg == ivf_pkg::ST_WAIT ##1 state_reg == ivf_pkg::ST_LATCH);
	cov_released:     cover property (state_reg == ivf_pkg::ST_LATCH && release_req);

endmodule

// ===== test/ivf_host_model.sv
// Host controller model driving the register command port.
// Assumes the bench calls its tasks and shares the system clock.
`timescale 1ns/10ps
module ivf_host_model (
	// Clock
	input  wire logic        clk_sys_i,
	// Register command port
	output logic             wr_en_o,
	output logic             rd_en_o,
	output logic      [7:0]  cmd_code_o,
	output logic      [15:0] wr_data_o,
	input  wire logic [15:0] rd_data_i,
	input  wire logic        rd_valid_i
);
	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		cmd_code_o = 8'hFF;
		wr_data_o = 16'hFFFF;
	end
	// Writes one whole word; released lines show the inverse value.
	task automatic write(input logic [7:0] c, input logic [15:0] d);
		@(posedge clk_sys_i);
		#1;
		wr_en_o = 1'b1;
		cmd_code_o = c;
		wr_data_o = d;
		@(posedge clk_sys_i);
		#1;
		wr_en_o = 1'b0;
		cmd_code_o = ~c;
		wr_data_o = ~d;
	endtask
	// Reads one word; the answer stands in the cycle after the strobe.
	task automatic read(input logic [7:0] c, output logic [15:0] d, output logic v);
		@(posedge clk_sys_i);
		#1;
		rd_en_o = 1'b1;
		cmd_code_o = c;
		@(posedge clk_sys_i);
		#1;
		d = rd_data_i;
		v = rd_valid_i;
		rd_en_o = 1'b0;
		cmd_code_o = ~c;
	endtask
	// Writes one word and reads it back at the very next edge.
	task automatic write_read(input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(posedge clk_sys_i);
		#1;
		wr_en_o = 1'b1;
		cmd_code_o = c;
		wr_data_o = d;
		@(posedge clk_sys_i);
		#1;
		wr_en_o = 1'b0;
		rd_en_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		q = rd_data_i;
		v = rd_valid_i;
		rd_en_o = 1'b0;
		cmd_code_o = ~c;
		wr_data_o = ~d;
	endtask
endmodule

// ===== test/ivf_top_tb_top.sv
// Self-checking bench for the input-voltage supervision block.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/10ps
module ivf_top_tb_top;
	typedef struct {
		logic [7:0]  cmd;
		logic [15:0] wdat;
		logic [15:0] rexp;
	} ivf_row_s;
	localparam logic [15:0] V_LOW  = 16'h0050;
	localparam logic [15:0] V_GOOD = 16'h00C8;
	localparam logic [15:0] V_HIGH = 16'h0200;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        wr_en, rd_en, rd_valid, clear_faults, on_cmd, other_fault;
	logic        out_en, uv_fault, uv_warn, ov_warn, v;
	logic [7:0]  cmd;
	logic [15:0] wr_data, rd_data, vin, d;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          n, e, u, dd;
	ivf_row_s    rows [5] = '{
		'{ivf_pkg::ADDR_OV_WARN, 16'hABCD, 16'hABCD},
		'{ivf_pkg::ADDR_UV_WARN, 16'h1234, 16'h1234},
		'{ivf_pkg::ADDR_UV_FAULT, 16'h5A5A, 16'h5A5A},
		'{ivf_pkg::ADDR_UV_ACTION, 16'h12FF, 16'h00FF},
		'{8'h33, 16'h7777, 16'h0000}};
	always #12.5 clk_sys_i = ~clk_sys_i;
	ivf_host_model host_u (.clk_sys_i(clk_sys_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
		.cmd_code_o(cmd), .wr_data_o(wr_data), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
	ivf_top dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en),
		.rd_en_i(rd_en), .cmd_code_i(cmd), .wr_data_i(wr_data), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .clear_faults_i(clear_faults), .on_cmd_i(on_cmd),
		.other_fault_i(other_fault), .vin_meas_i(vin), .out_enable_o(out_en),
		.uv_fault_o(uv_fault), .uv_warn_o(uv_warn), .ov_warn_o(ov_warn));
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic clr();
		vin = V_GOOD;
		clear_faults = 1'b1;
		on_cmd = 1'b0;
		cyc(1);
		clear_faults = 1'b0;
		on_cmd = 1'b1;
		cyc(2);
	endtask
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(25 * 40000);
		num_errors++;
		give_verdict();
	end
	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{clear_faults, other_fault} = 2'b00;
		on_cmd = 1'b1;
		vin = V_GOOD;
		cyc(12);
		reset_n_i = 1'b1;
		host_u.read(ivf_pkg::ADDR_OV_WARN, d, v);
		check(d, ivf_pkg::RST_THRESHOLD);
		host_u.read(ivf_pkg::ADDR_UV_ACTION, d, v);
		check(d, {8'h00, ivf_pkg::RST_ACTION});
		host_u.read(ivf_pkg::ADDR_TIME_UNIT, d, v);
		check(d, ivf_pkg::RST_TIME_UNIT);
		foreach (rows[i]) begin
			host_u.write_read(rows[i].cmd, rows[i].wdat, d, v);
			check(v, 1'b1);
			check(d, rows[i].rexp);
		end
		host_u.write(ivf_pkg::ADDR_UV_FAULT, 16'h0064);
		host_u.write(ivf_pkg::ADDR_UV_WARN, 16'h0080);
		host_u.write(ivf_pkg::ADDR_OV_WARN, 16'h0100);
		host_u.write(ivf_pkg::ADDR_UV_ACTION, 16'h0000);
		clr();
		vin = V_LOW;
		cyc(100);
		check(out_en, 1'b1);
		check({uv_fault, uv_warn, ov_warn}, 3'b110);
		vin = V_HIGH;
		cyc(3);
		check(ov_warn, 1'b1);
		clr();
		for (int i = 0; i < 5; i++) begin
			u = (i == 4) ? 3 : 1;
			dd = (i == 4) ? 1 : i;
			e = 40 * u * (1 << dd);
			host_u.write(ivf_pkg::ADDR_TIME_UNIT, 16'(u));
			host_u.write(ivf_pkg::ADDR_UV_ACTION, {8'h00, 2'b01, 3'b000, 3'(dd)});
			vin = V_LOW;
			n = 0;
			while (out_en === 1'b1 && n < 3000) begin
				cyc(1);
				n++;
			end
			check(n >= e - 3 && n <= e + 3, 1'b1);
			vin = V_GOOD;
			cyc(300);
			check(out_en, 1'b0);
			clr();
		end
		host_u.write(ivf_pkg::ADDR_TIME_UNIT, 16'h0001);
		host_u.write(ivf_pkg::ADDR_UV_ACTION, 16'h0089);
		vin = V_LOW;
		cyc(2);
		check(out_en, 1'b0);
		cyc(300);
		vin = V_GOOD;
		cyc(100);
		check(out_en, 1'b0);
		on_cmd = 1'b0;
		cyc(2);
		on_cmd = 1'b1;
		cyc(2);
		check(out_en, 1'b1);
		vin = V_LOW;
		cyc(20);
		vin = V_GOOD;
		cyc(100);
		check(out_en, 1'b1);
		host_u.write(ivf_pkg::ADDR_UV_ACTION, 16'h00C0);
		for (int j = 0; j < 2; j++) begin
			vin = V_LOW;
			cyc(2);
			check(out_en, 1'b0);
			vin = V_GOOD;
			cyc(300);
			check(out_en, 1'b0);
			if (j == 0)
				host_u.write(ivf_pkg::ADDR_STATUS, 16'h0001);
			else
				clear_faults = 1'b1;
			cyc(1);
			clear_faults = 1'b0;
			cyc(2);
			check(out_en, 1'b1);
		end
		host_u.write(ivf_pkg::ADDR_UV_ACTION, 16'h00B8);
		vin = V_LOW;
		cyc(1000);
		check(out_en, 1'b0);
		vin = V_GOOD;
		cyc(60);
		check(out_en, 1'b1);
		other_fault = 1'b1;
		cyc(3);
		check(out_en, 1'b0);
		other_fault = 1'b0;
		clr();
		reset_n_i = 1'b0;
		cyc(2);
		reset_n_i = 1'b1;
		check(out_en, 1'b1);
		host_u.read(ivf_pkg::ADDR_UV_FAULT, d, v);
		check(d, ivf_pkg::RST_THRESHOLD);
		give_verdict();
	end
endmodule
